// ---- core/i2as_core.sv ----
/*
  I2C slave-side data, status code and own-address block with a
  Wishbone classic register slave and an interrupt output.
  Assumes a master engine elsewhere reports master mode and sent
  START or STOP as one-cycle pulses on mclk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "i2as_regs.svh"

module i2as_core
  import i2as_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Wishbone classic slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // I2C lines, open drain.
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Rest of the controller.
  input wire logic masterActive,
  input wire logic startSent,
  input wire logic stopSent,
  output logic startRequest,
  output logic stopRequest,
  // Interrupt.
  output logic irq
);

  // ----------------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------------
  i2as_core_t st;  // Registered state.
  i2as_core_t next_st;  // Next value.
  i2as_line_if ln ();  // Synchronised line events.
  logic busReq;  // A bus request not yet answered.
  logic postNow;  // A new bus state is published this cycle.
  logic [7:0] postCode;  // Code of that bus state.
  logic [2:0] hitNow;  // Address compare result.
  logic gcNow;  // General call seen and enabled.
  logic evalAddr;  // Address byte complete this cycle.

  // Compares a received address with one own address.
  function automatic logic addr_hit(input logic [6:0] a,
                                    input logic [6:0] own);
    addr_hit = (a == own) && (own != `I2AS_RST_ADR);
  endfunction : addr_hit

  // ----------------------------------------------------------------------
  // Line watcher.
  // ----------------------------------------------------------------------
  i2as_line_watch u_watch (
    .mclk(mclk),
    .rst(rst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .ln(ln)
  );

  assign busReq = cyc_i & stb_i & ~st.ack;
  assign evalAddr = (st.state == ST_ADDR) && ln.sclFall &&
                    (st.bitCnt == `I2AS_BITS) && !ln.startSeen &&
                    !ln.stopSeen;
  assign hitNow = {addr_hit(st.shift[7:1], st.adr2),
                   addr_hit(st.shift[7:1], st.adr1),
                   addr_hit(st.shift[7:1], st.adr0)};
  assign gcNow = (st.shift[7:1] == `I2AS_RST_ADR) && !st.shift[0] &&
                 st.gcEn;

  // ----------------------------------------------------------------------
  // Next state: bus writes first, hardware events after, so a hardware event wins.
  // ----------------------------------------------------------------------
  always_comb begin
    next_st = st;
    postNow = 1'b0;
    postCode = `I2AS_C_IDLE;
    next_st.ack = busReq;
    next_st.rdata = '0;
    if (busReq && !we_i) begin
      // Reserved bits are simply never placed in the word.
      unique case (adr_i)
        `I2AS_OFF_CTRL: next_st.rdata[5:2] =
          {st.startReq, st.stopReq, st.si, st.ackCtl};
        `I2AS_OFF_DATA: next_st.rdata[7:0] = st.data;
        `I2AS_OFF_ADR0: next_st.rdata[7:0] = {st.adr0, st.gcEn};
        `I2AS_OFF_CODE: next_st.rdata[7:0] = st.code;
        `I2AS_OFF_ADR1: next_st.rdata[7:1] = st.adr1;
        `I2AS_OFF_ADR2: next_st.rdata[7:1] = st.adr2;
        `I2AS_OFF_HIT: next_st.rdata[2:0] = st.hit;
        `I2AS_OFF_ISTAT: next_st.rdata[2:0] = st.intStat;
        `I2AS_OFF_IMASK: next_st.rdata[2:0] = st.intMask;
        default: next_st.rdata = '0;
      endcase
    end
    if (busReq && we_i && sel_i[0]) begin
      unique case (adr_i)
        `I2AS_OFF_CTRL: begin
          next_st.ackCtl = dat_i[`I2AS_CTRL_ACK];
          next_st.stopReq = dat_i[`I2AS_CTRL_STOP];
          next_st.startReq = dat_i[`I2AS_CTRL_START];
          // Writing zero to the flag releases the engine.
          if (!dat_i[`I2AS_CTRL_SI]) begin
            next_st.si = 1'b0;
            next_st.code = `I2AS_C_IDLE;
          end
        end
        `I2AS_OFF_DATA: next_st.data = dat_i[7:0];
        `I2AS_OFF_ADR0: begin
          next_st.adr0 = dat_i[7:1];
          next_st.gcEn = dat_i[0];
        end
        `I2AS_OFF_ADR1: next_st.adr1 = dat_i[7:1];
        `I2AS_OFF_ADR2: next_st.adr2 = dat_i[7:1];
        `I2AS_OFF_ISTAT: next_st.intStat = st.intStat & ~dat_i[2:0];
        `I2AS_OFF_IMASK: next_st.intMask = dat_i[2:0];
        default: next_st.rdata = '0;
      endcase
    end
    // A sent STOP ends the STOP request; a sent START leaves the START request set.
    if (stopSent) begin
      next_st.stopReq = 1'b0;
    end

    // Link engine.
    if (ln.startSeen) begin
      if (st.state != ST_IDLE && st.state != ST_ADDR) begin
        postNow = 1'b1;
        postCode = `I2AS_C_STOP;
      end
      next_st.state = ST_ADDR;
      next_st.bitCnt = 4'h0;
      next_st.hit = 3'h0;
      next_st.ackDrive = 1'b0;
      next_st.sdaDrive = 1'b0;
    end else if (ln.stopSeen) begin
      if (st.state != ST_IDLE && st.state != ST_ADDR) begin
        postNow = 1'b1;
        postCode = `I2AS_C_STOP;
      end
      next_st.state = ST_IDLE;
      next_st.ackDrive = 1'b0;
      next_st.sdaDrive = 1'b0;
      next_st.intStat[`I2AS_INT_STOP] = 1'b1;
    end else begin
      unique case (st.state)
        ST_IDLE: begin
          next_st.sdaDrive = 1'b0;
        end
        ST_ADDR, ST_RX: begin
          if (ln.sclRise) begin
            next_st.shift = {st.shift[6:0], ln.sdaLevel};
            next_st.bitCnt = st.bitCnt + 4'h1;
          end
          if (evalAddr) begin
            next_st.bitCnt = 4'h0;
            next_st.state = ST_IDLE;
            // Own addresses mean nothing to a master.
            if (!masterActive) begin
              next_st.hit = hitNow;
              if ((|hitNow || gcNow) && st.ackCtl) begin
                next_st.ackDrive = 1'b1;
                next_st.state = ST_ACK;
                next_st.read = st.shift[0];
                next_st.gcMode = gcNow && !(|hitNow);
                // Sticky: a general call alone must not clear an old hit.
                next_st.intStat[`I2AS_INT_HIT] =
                  next_st.intStat[`I2AS_INT_HIT] | (|hitNow);
                next_st.pendCode = (gcNow && !(|hitNow)) ?
                  `I2AS_C_GCALL : (st.shift[0] ? `I2AS_C_SLAR :
                  `I2AS_C_SLAW);
              end
            end
          end else if (st.state == ST_RX && ln.sclFall &&
                       st.bitCnt == `I2AS_BITS) begin
            next_st.data = st.shift;
            next_st.bitCnt = 4'h0;
            next_st.ackDrive = st.ackCtl;
            next_st.state = ST_ACK;
            if (st.gcMode) begin
              next_st.pendCode = st.ackCtl ? `I2AS_C_GCACK :
                                             `I2AS_C_GCNACK;
            end else begin
              next_st.pendCode = st.ackCtl ? `I2AS_C_RXACK :
                                             `I2AS_C_RXNACK;
            end
          end
        end
        ST_ACK: begin
          // The acknowledge bit ends at this falling edge.
          if (ln.sclFall) begin
            postNow = 1'b1;
            postCode = st.pendCode;
            next_st.ackDrive = 1'b0;
            next_st.bitCnt = 4'h0;
            next_st.txLoad = st.read;
            next_st.state = !st.ackDrive ? ST_IDLE :
                            (st.read ? ST_TX : ST_RX);
          end
        end
        ST_TX: begin
          // The byte is taken once software releases the clock.
          if (st.txLoad) begin
            if (!st.si) begin
              next_st.txLoad = 1'b0;
              next_st.shift = st.data;
              next_st.sdaDrive = ~st.data[7];
            end
          end else begin
            if (ln.sclRise) begin
              next_st.bitCnt = st.bitCnt + 4'h1;
            end
            if (ln.sclFall) begin
              if (st.bitCnt == `I2AS_BITS) begin
                next_st.sdaDrive = 1'b0;
                next_st.state = ST_TXACK;
              end else begin
                next_st.shift = {st.shift[6:0], 1'b0};
                next_st.sdaDrive = ~st.shift[6];
              end
            end
          end
        end
        ST_TXACK: begin
          if (ln.sclRise) begin
            next_st.masterAck = ~ln.sdaLevel;
          end
          if (ln.sclFall) begin
            postNow = 1'b1;
            next_st.bitCnt = 4'h0;
            next_st.state = ST_IDLE;
            if (!st.masterAck) begin
              postCode = `I2AS_C_TXNACK;
            end else if (!st.ackCtl) begin
              postCode = `I2AS_C_TXLAST;
            end else begin
              postCode = `I2AS_C_TXACK;
              next_st.state = ST_TX;
              next_st.txLoad = 1'b1;
            end
          end
        end
        default: next_st.state = ST_IDLE;
      endcase
    end
    // A sent START or STOP clears the hit flags after the engine, so the
    // clear wins over an address compare in the same cycle.
    if (startSent || stopSent) begin
      next_st.hit = 3'h0;
    end
    // Publishing a bus state sets the flag and interrupt last.
    if (postNow) begin
      next_st.code = postCode;
      next_st.si = 1'b1;
      next_st.intStat[`I2AS_INT_SI] = 1'b1;
    end
  end

  // Registers the state; every field takes a constant on reset.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.code <= `I2AS_C_IDLE;
      st.state <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign dat_o = st.rdata;
  assign ack_o = st.ack;
  assign sclOut = 1'b0;
  assign sclOe = st.si;
  assign sdaOut = 1'b0;
  assign sdaOe = st.sdaDrive | st.ackDrive;
  assign startRequest = st.startReq;
  assign stopRequest = st.stopReq;
  assign irq = |(st.intStat & st.intMask);

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  idle_flag_clear_a: assert property (
    (st.code == `I2AS_C_IDLE) == !st.si)
    else $error("Idle code and state flag disagree");

  code_load_flag_a: assert property (
    (st.code != $past(st.code) && st.code != `I2AS_C_IDLE) |->
      st.si && st.intStat[`I2AS_INT_SI])
    else $error("New code without flag or interrupt");

  primary_ack_a: assert property (
    (evalAddr && !masterActive && hitNow[0] && st.ackCtl) |=>
      (st.state == ST_ACK) && sdaOe[*2])
    else $error("Primary address not acknowledged");

  gc_ignore_a: assert property (
    (evalAddr && gcNow && !(|hitNow) && !st.ackCtl) |=>
      st.state == ST_IDLE && !sdaOe)
    else $error("General call answered without ack control");

  master_ignore_a: assert property (
    (evalAddr && masterActive) |=>
      st.state == ST_IDLE && st.hit == $past(st.hit))
    else $error("Own address used in master mode");

  hit_flags_a: assert property (
    (evalAddr && !masterActive && !startSent && !stopSent) |=>
      st.hit == $past(hitNow))
    else $error("Hit flags do not follow compare");

  hit_clear_a: assert property (
    (startSent || stopSent || ln.startSeen) |=> st.hit == 3'h0)
    else $error("Hit flags not cleared");

  scl_hold_a: assert property (
    $fell(sclOe) |-> $past(busReq) && $past(we_i) && $past(sel_i[0]) &&
      $past(adr_i) == `I2AS_OFF_CTRL && !$past(dat_i[`I2AS_CTRL_SI]))
    else $error("Clock released without a flag clear");

  rx_byte_a: assert property (
    ($past(st.state) == ST_RX && st.state == ST_ACK) |->
      st.data == $past(st.shift))
    else $error("Received byte not stored");

  ack_select_a: assert property (
    (st.state == ST_RX && ln.sclFall && st.bitCnt == `I2AS_BITS &&
     !ln.startSeen && !ln.stopSeen) |=> sdaOe == $past(st.ackCtl))
    else $error("Acknowledge phase ignores ack control");

  reserved_zero_a: assert property (
    ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("Reserved bits read nonzero");

endmodule : i2as_core

`default_nettype wire

// ---- core/i2as_line_if.sv ----
/*
  Interface that carries synchronised line events from the watcher
  to the core. Assumes both ends run on mclk.
*/
`timescale 1ns/100ps
`default_nettype none

interface i2as_line_if;
  logic sclRise;  // Clock line went high.
  logic sclFall;  // Clock line went low.
  logic startSeen;  // START or repeated START on the bus.
  logic stopSeen;  // STOP on the bus.
  logic sdaLevel;  // Synchronised data line level.
  modport watch (output sclRise, sclFall, startSeen, stopSeen, sdaLevel);
  modport user (input sclRise, sclFall, startSeen, stopSeen, sdaLevel);
endinterface : i2as_line_if

`default_nettype wire

// ---- core/i2as_line_watch.sv ----
/*
  Two-flop synchroniser and edge, START and STOP detector for the I2C
  lines. Assumes SCL and SDA arrive asynchronously to mclk and are far
  slower than it.
*/
`timescale 1ns/100ps
`default_nettype none

module i2as_line_watch
  import i2as_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Raw bus lines.
  input wire logic sclIn,
  input wire logic sdaIn,
  // Events towards the core.
  i2as_line_if.watch ln
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  i2as_watch_t st;  // Registered state.
  i2as_watch_t next_st;  // Next value.

  // First stages feed only second stages; lines idle high.
  always_comb begin
    next_st = st;
    next_st.sclS1 = sclIn;
    next_st.sclS2 = st.sclS1;
    next_st.sdaS1 = sdaIn;
    next_st.sdaS2 = st.sdaS1;
    next_st.sclPrev = st.sclS2;
    next_st.sdaPrev = st.sdaS2;
  end

  // Reset to the idle-high level so no false START appears.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Events, looked at from the second stage onward.
  // ----------------------------------------------------------------------
  assign ln.sclRise = st.sclS2 & ~st.sclPrev;
  assign ln.sclFall = ~st.sclS2 & st.sclPrev;
  assign ln.startSeen = st.sclS2 & st.sclPrev & st.sdaPrev & ~st.sdaS2;
  assign ln.stopSeen = st.sclS2 & st.sclPrev & ~st.sdaPrev & st.sdaS2;
  assign ln.sdaLevel = st.sdaS2;

endmodule : i2as_line_watch

`default_nettype wire

// ---- core/i2as_pkg.sv ----
/*
  Types of the I2C slave address, data and status block.
  Assumes the register header supplies all numeric constants.
*/
package i2as_pkg;

  // --------------------------------------------------------------------
  // Link engine states.
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_TXACK = 3'b101
  } i2as_state_t;

  // Whole state of the core module.
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic ackCtl;
    logic si;
    logic stopReq;
    logic startReq;
    logic [7:0] data;
    logic [7:0] code;
    logic [6:0] adr0;
    logic [6:0] adr1;
    logic [6:0] adr2;
    logic gcEn;
    logic [2:0] hit;
    logic [2:0] intStat;
    logic [2:0] intMask;
    i2as_state_t state;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic ackDrive;
    logic sdaDrive;
    logic read;
    logic gcMode;
    logic txLoad;
    logic masterAck;
    logic [7:0] pendCode;
  } i2as_core_t;

  // Whole state of the line watcher.
  typedef struct packed {
    logic sclS1;
    logic sclS2;
    logic sdaS1;
    logic sdaS2;
    logic sclPrev;
    logic sdaPrev;
  } i2as_watch_t;

endpackage : i2as_pkg

// ---- core/i2as_regs.svh ----
/*
  Register offsets, field positions, reset values and bus state codes of
  the I2C slave address, data and status block.
  Assumes inclusion by bare name from the core files and the bench.
*/
`ifndef I2AS_REGS_SVH
`define I2AS_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the Wishbone slave.
// ----------------------------------------------------------------------
`define I2AS_OFF_CTRL 8'h00
`define I2AS_OFF_DATA 8'h0c
`define I2AS_OFF_ADR0 8'h10
`define I2AS_OFF_CODE 8'h14
`define I2AS_OFF_ADR1 8'h20
`define I2AS_OFF_ADR2 8'h24
`define I2AS_OFF_HIT 8'h28
`define I2AS_OFF_ISTAT 8'h2c
`define I2AS_OFF_IMASK 8'h30

// ----------------------------------------------------------------------
// Control register bit positions.
// ----------------------------------------------------------------------
`define I2AS_CTRL_ACK 2
`define I2AS_CTRL_SI 3
`define I2AS_CTRL_STOP 4
`define I2AS_CTRL_START 5

// ----------------------------------------------------------------------
// Interrupt status bit positions.
// ----------------------------------------------------------------------
`define I2AS_INT_SI 0
`define I2AS_INT_HIT 1
`define I2AS_INT_STOP 2

// ----------------------------------------------------------------------
// Reset values, counts and bus state codes.
// ----------------------------------------------------------------------
`define I2AS_RST_BYTE 8'h00
`define I2AS_RST_ADR 7'h00
`define I2AS_BITS 4'h8
`define I2AS_C_IDLE 8'hf8
`define I2AS_C_SLAW 8'h60
`define I2AS_C_GCALL 8'h70
`define I2AS_C_RXACK 8'h80
`define I2AS_C_RXNACK 8'h88
`define I2AS_C_GCACK 8'h90
`define I2AS_C_GCNACK 8'h98
`define I2AS_C_STOP 8'ha0
`define I2AS_C_SLAR 8'ha8
`define I2AS_C_TXACK 8'hb8
`define I2AS_C_TXNACK 8'hc0
`define I2AS_C_TXLAST 8'hc8

`endif

// ---- verification/i2as_core_bench.sv ----
/*
  Self-checking bench of the I2C slave address, data and status core.
  Assumes the link master model and pull-ups on both lines.
*/
`timescale 1ns/100ps
`default_nettype none
`include "i2as_regs.svh"

module i2as_core_bench;
  // ----------------------------------------------------------------
  // Stimulus, outputs and the resolved open-drain lines.
  // ----------------------------------------------------------------
  logic mclk, rst, cyc_i, stb_i, we_i, masterActive, startSent, stopSent;
  logic [7:0] adr_i, rxb;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic ack_o, sclOut, sclOe, sdaOut, sdaOe, irq, startRequest, stopRequest;
  logic sclLow, sdaLow, linkHang, ackd;
  wire scl = ~(sclLow | sclOe);
  wire sda = ~(sdaLow | sdaOe);
  int errors, checks_done, i;
  // Own addresses; zero is never used since it means general call.
  logic [6:0] own [3] = '{7'h50, 7'h31, 7'h22};
  // Refused cases: address byte, primary register, control, master.
  logic [31:0] refuse [5] = '{32'h22a10400, 32'ha0a10000, 32'ha0a10401,
    32'h00a00400, 32'h00a10000};

  i2as_core i_i2as_core (.mclk(mclk), .rst(rst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sclIn(scl),
    .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .masterActive(masterActive), .startSent(startSent),
    .stopSent(stopSent), .startRequest(startRequest),
    .stopRequest(stopRequest), .irq(irq));

  i2as_link_master i_i2as_link_master (.sclLine(scl), .sdaLine(sda),
    .sclLow(sclLow), .sdaLow(sdaLow), .linkHang(linkHang));

  // 10 MHz system clock.
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Tasks.
  // ----------------------------------------------------------------
  // Report counts and the verdict; a hung link counts as a mismatch.
  task automatic end_sim(input int extra);
    errors += extra + int'(linkHang);
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // Count one comparison and report a difference at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle held until ack is sampled; only then released.
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge mclk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) end_sim(1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr

  // Every register keeps its value in the low byte, the rest reads 0.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, {24'h0, exp});
  endtask : rd

  // The core must stretch SCL once a bus state is reported.
  task automatic hold;
    int n;
    for (n = 0; n < 300 && sclOe !== 1'b1; n++) @(negedge mclk);
    if (n >= 300) end_sim(1);
  endtask : hold

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h0;
    dat_i = 32'h0;
    sel_i = 4'hf;
    masterActive = 1'b0;
    startSent = 1'b0;
    stopSent = 1'b0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    rd(`I2AS_OFF_DATA, 8'h0);
    rd(`I2AS_OFF_CODE, 8'hf8);
    rd(`I2AS_OFF_ADR0, 8'h0);
    rd(`I2AS_OFF_HIT, 8'h0);
    wr(`I2AS_OFF_ADR1, 32'hffffffff);
    rd(`I2AS_OFF_ADR1, 8'hfe);
    wr(`I2AS_OFF_CODE, 32'h0);
    rd(`I2AS_OFF_CODE, 8'hf8);
    wr(`I2AS_OFF_DATA, 32'hffffff5a);
    rd(`I2AS_OFF_DATA, 8'h5a);
    wr(8'h3c, 32'hffffffff);
    rd(8'h3c, 8'h0);
    // Request bits reach their outputs; a sent STOP ends its request.
    wr(`I2AS_OFF_CTRL, 32'h30);
    rd(`I2AS_OFF_CTRL, 8'h30);
    chk({28'h0, startRequest, stopRequest, sclOut, sdaOut}, 32'hc);
    stopSent <= 1'b1;
    @(posedge mclk);
    stopSent <= 1'b0;
    rd(`I2AS_OFF_CTRL, 8'h20);
    $display("register test done");
    // Each own address in turn; the primary one also answers calls.
    wr(`I2AS_OFF_ADR0, {24'h0, own[0], 1'b1});
    wr(`I2AS_OFF_ADR1, {24'h0, own[1], 1'b0});
    wr(`I2AS_OFF_ADR2, {24'h0, own[2], 1'b0});
    wr(`I2AS_OFF_CTRL, 32'h4);
    for (i = 0; i < 3; i++) begin
      i_i2as_link_master.start_cond();
      i_i2as_link_master.put_byte({own[i], 1'b0}, ackd);
      chk({31'h0, ackd}, 32'h1);
      hold();
      rd(`I2AS_OFF_CODE, `I2AS_C_SLAW);
      rd(`I2AS_OFF_HIT, 8'h1 << i);
      if (i == 0) begin
        chk({31'h0, irq}, 32'h0);
        wr(`I2AS_OFF_IMASK, 32'h7);
        @(negedge mclk);
        chk({31'h0, irq}, 32'h1);
        wr(`I2AS_OFF_ISTAT, 32'h7);
        @(negedge mclk);
        chk({31'h0, irq}, 32'h0);
      end else begin
        startSent <= (i == 1);
        stopSent <= (i == 2);
        @(posedge mclk);
        startSent <= 1'b0;
        stopSent <= 1'b0;
        rd(`I2AS_OFF_HIT, 8'h0);
      end
      wr(`I2AS_OFF_CTRL, 32'h4);
      i_i2as_link_master.stop_cond();
      hold();
      rd(`I2AS_OFF_CODE, `I2AS_C_STOP);
      wr(`I2AS_OFF_CTRL, 32'h4);
      rd(`I2AS_OFF_CODE, 8'hf8);
    end
    $display("address test done");
    // Receive: one byte acknowledged, the next refused.
    i_i2as_link_master.start_cond();
    i_i2as_link_master.put_byte({own[1], 1'b0}, ackd);
    hold();
    wr(`I2AS_OFF_CTRL, 32'h4);
    i_i2as_link_master.put_byte(8'ha5, ackd);
    chk({31'h0, ackd}, 32'h1);
    hold();
    rd(`I2AS_OFF_CODE, `I2AS_C_RXACK);
    rd(`I2AS_OFF_DATA, 8'ha5);
    wr(`I2AS_OFF_CTRL, 32'h0);
    i_i2as_link_master.put_byte(8'h3c, ackd);
    chk({31'h0, ackd}, 32'h0);
    hold();
    rd(`I2AS_OFF_CODE, `I2AS_C_RXNACK);
    wr(`I2AS_OFF_CTRL, 32'h4);
    i_i2as_link_master.stop_cond();
    $display("receive test done");
    // Transmit one byte to the remote master, which refuses more.
    i_i2as_link_master.start_cond();
    i_i2as_link_master.put_byte({own[2], 1'b1}, ackd);
    hold();
    rd(`I2AS_OFF_CODE, `I2AS_C_SLAR);
    wr(`I2AS_OFF_DATA, 32'hc3);
    wr(`I2AS_OFF_CTRL, 32'h4);
    i_i2as_link_master.get_byte(rxb, 1'b0);
    chk({24'h0, rxb}, 32'hc3);
    hold();
    rd(`I2AS_OFF_CODE, `I2AS_C_TXNACK);
    wr(`I2AS_OFF_CTRL, 32'h4);
    i_i2as_link_master.stop_cond();
    $display("transmit test done");
    // General call accepted, then its data refused with ack off.
    i_i2as_link_master.start_cond();
    i_i2as_link_master.put_byte(8'h00, ackd);
    chk({31'h0, ackd}, 32'h1);
    hold();
    rd(`I2AS_OFF_CODE, `I2AS_C_GCALL);
    wr(`I2AS_OFF_CTRL, 32'h0);
    i_i2as_link_master.put_byte(8'h00, ackd);
    chk({31'h0, ackd}, 32'h0);
    hold();
    rd(`I2AS_OFF_CODE, `I2AS_C_GCNACK);
    wr(`I2AS_OFF_CTRL, 32'h4);
    i_i2as_link_master.stop_cond();
    $display("general call test done");
    // Stranger, ack off, master mode, general call off, call with ack off.
    for (i = 0; i < 5; i++) begin
      wr(`I2AS_OFF_ADR0, {24'h0, refuse[i][23:16]});
      wr(`I2AS_OFF_CTRL, {24'h0, refuse[i][15:8]});
      masterActive <= refuse[i][0];
      i_i2as_link_master.start_cond();
      i_i2as_link_master.put_byte(refuse[i][31:24], ackd);
      chk({31'h0, ackd}, 32'h0);
      i_i2as_link_master.stop_cond();
      rd(`I2AS_OFF_CODE, 8'hf8);
    end
    masterActive <= 1'b0;
    $display("refusal test done");
    end_sim(0);
  end
endmodule : i2as_core_bench

`default_nettype wire

// ---- verification/i2as_link_master.sv ----
/*
  Behavioural remote I2C master that drives the open-drain SCL and SDA.
  Assumes pull-ups on both lines, resolved by the bench from all pulls.
*/
`timescale 1ns/100ps
`default_nettype none

module i2as_link_master (
  // Resolved bus lines.
  input wire logic sclLine,
  input wire logic sdaLine,
  // Pull requests, high pulls the line low.
  output logic sclLow,
  output logic sdaLow,
  // Set when a stretched clock never came back.
  output logic linkHang
);
  // Quarter of the 800 ns link period.
  localparam int Q = 200;

  // Both lines released, so the pull-ups hold the bus idle.
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
    linkHang = 1'b0;
  end

  // Release SCL and wait while the slave stretches it; bounded.
  task automatic scl_up;
    int n;
    sclLow = 1'b0;
    for (n = 0; n < 400 && sclLine !== 1'b1; n++) #50;
    if (n >= 400) linkHang = 1'b1;
  endtask : scl_up

  // One bit: drive d, sample the line in mid high phase.
  task automatic bit_io(input logic d, output logic s);
    sdaLow = ~d;
    #Q;
    scl_up();
    #Q;
    s = sdaLine;
    #Q;
    sclLow = 1'b1;
    #Q;
  endtask : bit_io

  // START: SDA falls while SCL is high.
  task automatic start_cond;
    sdaLow = 1'b1;
    #Q;
    sclLow = 1'b1;
    #Q;
  endtask : start_cond

  // STOP: SDA rises while SCL is high; the master lets go of both.
  task automatic stop_cond;
    sdaLow = 1'b1;
    #Q;
    scl_up();
    #Q;
    sdaLow = 1'b0;
    #(2 * Q);
  endtask : stop_cond

  // Send a byte MSB first and report whether the slave acknowledged.
  task automatic put_byte(input logic [7:0] b, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    acked = ~s;
  endtask : put_byte

  // Take a byte MSB first, then answer ACK or NACK.
  task automatic get_byte(output logic [7:0] b, input logic ackIt);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(~ackIt, s);
  endtask : get_byte
endmodule : i2as_link_master

`default_nettype wire
